// *** common/rss_params.svh ***
/*
 constants for the regulator start-up sequencer: timing counts and reset values.
 assumes a 100 MHz system clock.
*/
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH
`define RSS_CLK_HZ 100000000
`define RSS_CHG_MOD_HZ 35000
// half period of the status modulation, rounded down so the rate is never slower
`define RSS_CHG_HALF_CYC (`RSS_CLK_HZ / (2 * `RSS_CHG_MOD_HZ))
`define RSS_CHG_PERIOD_CYC (2 * `RSS_CHG_HALF_CYC)
`define RSS_DUTY_LOW_CYC (`RSS_CHG_PERIOD_CYC / 8)
`define RSS_DUTY_HIGH_CYC ((`RSS_CHG_PERIOD_CYC * 7) / 8)
`define RSS_SETPOINT_RST 4'h0
`define RSS_SLOW_DEFAULT 4096
`endif

// *** common/rss_pkg.sv ***
/*
 types shared by the regulator start-up sequencer.
 assumes the constants header is included by the design file.
*/
package rss_pkg;
    typedef enum logic [1:0] {RSS_CHG_ON, RSS_CHG_OFF, RSS_CHG_BADBAT, RSS_CHG_TEMP} rss_chg_t;
    typedef enum logic [1:0] {RSS_SEQ_GND, RSS_SEQ_HIGH, RSS_SEQ_FLOAT} rss_seqsel_t;
    typedef struct packed {
        logic buck1;
        logic buck2;
        logic buckboost;
    } rss_regs_t;
endpackage : rss_pkg

// *** verilog/rss_sequencer.sv ***
/*
 regulator start-up sequencer: ordered enable of three regulators, host override,
 all-power-good open-drain output, set-point codes and charge status modulation.
 assumes the serial-port decoder delivers host commands as same-clock levels and
 that settled flags, thermistor and battery flags come from analog comparators.
*/
// Operation
// - enable-all high turns on all three regulators one after another in selected order
// - select ground: b1,b2,bb; high: b1,bb,b2; floating: bb,b1,b2
// - host may enable or disable each regulator separately over the serial port; ored with sequence enables, host cannot turn off a sequenced one
// - release all-power-good only when every enabled regulator has settled
// - regulators one and three take a 16-step set-point code from host
// - four charger states: on held low, off released, bad battery and thermal pause shown by 35kHz toggling at low or high duty
// - thermistor out of window pauses charging, resumes when back inside
`timescale 1ns/1ps
`include "rss_params.svh"

module rss_sequencer
    import rss_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // start-up pins, raw from outside
    input wire logic enable_all_input,
    input wire logic seq_tied_high,
    input wire logic seq_floating,
    // host commands from the serial-port decoder
    input wire rss_regs_t host_enable,
    input wire logic [3:0] host_setpoint1,
    input wire logic [3:0] host_setpoint3,
    input wire logic host_setpoint_load,
    // analog status, raw
    input wire rss_regs_t settled_in,
    input wire logic thermistor_input,
    input wire logic charger_active,
    input wire logic battery_bad,
    // regulator controls
    output rss_regs_t reg_enable,
    output logic [3:0] buck1_feedback,
    output logic [3:0] buckboost_feedback,
    output logic charge_pause,
    // open-drain outputs: oe high pulls the pin low
    output logic all_power_good_oe,
    output logic charge_status_out_oe
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    assign raw_in = {enable_all_input, seq_tied_high, seq_floating, settled_in,
                     thermistor_input, battery_bad};
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end
    logic en_all_s;
    logic seq_high_s;
    logic seq_float_s;
    rss_regs_t settled_s;
    logic temp_ok_s;
    logic bat_bad_s;
    assign {en_all_s, seq_high_s, seq_float_s, settled_s, temp_ok_s, bat_bad_s} = sync2_r;

    // ------------------------------------------------------------
    // start-up order
    // ------------------------------------------------------------
    rss_seqsel_t seqsel;
    assign seqsel = seq_float_s ? RSS_SEQ_FLOAT : (seq_high_s ? RSS_SEQ_HIGH : RSS_SEQ_GND);

    // one-hot regulator for step 0..2 of the chosen order
    function automatic rss_regs_t step_reg(input rss_seqsel_t sel, input logic [1:0] step);
        rss_regs_t r;
        r = '0;
        unique case (sel)
            RSS_SEQ_GND: r = (step == 2'd0) ? 3'b100 : (step == 2'd1) ? 3'b010 : 3'b001;
            RSS_SEQ_HIGH: r = (step == 2'd0) ? 3'b100 : (step == 2'd1) ? 3'b001 : 3'b010;
            RSS_SEQ_FLOAT: r = (step == 2'd0) ? 3'b001 : (step == 2'd1) ? 3'b100 : 3'b010;
            default: r = '0;
        endcase
        return r;
    endfunction : step_reg

    typedef enum logic [1:0] {RSS_IDLE, RSS_RAMP, RSS_DONE} rss_state_t;
    rss_state_t state_r;
    rss_state_t state_nxt;
    logic [1:0] step_r;
    logic [1:0] step_nxt;
    rss_regs_t seq_en_r;
    rss_regs_t seq_en_nxt;
    rss_seqsel_t order_r;
    rss_regs_t cur_reg;
    logic cur_settled;
    assign cur_reg = step_reg(order_r, step_r);
    assign cur_settled = |(cur_reg & settled_s);

    always_comb begin
        state_nxt = state_r;
        step_nxt = step_r;
        seq_en_nxt = seq_en_r;
        unique case (state_r)
            RSS_IDLE: begin
                if (en_all_s) begin
                    state_nxt = RSS_RAMP;
                    step_nxt = 2'd0;
                    seq_en_nxt = step_reg(seqsel, 2'd0);
                end
            end
            RSS_RAMP: begin
                if (!en_all_s) begin
                    state_nxt = RSS_IDLE;
                    seq_en_nxt = '0;
                end else if (cur_settled) begin
                    if (step_r == 2'd2) begin
                        state_nxt = RSS_DONE;
                    end else begin
                        step_nxt = step_r + 2'd1;
                        seq_en_nxt = seq_en_r | step_reg(order_r, step_r + 2'd1);
                    end
                end
            end
            RSS_DONE: begin
                if (!en_all_s) begin
                    state_nxt = RSS_IDLE;
                    seq_en_nxt = '0;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r <= RSS_IDLE;
            step_r <= 2'd0;
            seq_en_r <= '0;
            order_r <= RSS_SEQ_GND;
        end else begin
            state_r <= state_nxt;
            step_r <= step_nxt;
            seq_en_r <= seq_en_nxt;
            // order is frozen at the start so a moving select cannot skip a regulator
            if (state_r == RSS_IDLE) begin
                order_r <= seqsel;
            end
        end
    end

    // host enables are ored in: either path may turn a regulator on
    rss_regs_t enable_nxt;
    assign enable_nxt = seq_en_r | host_enable;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_enable <= '0;
        end else begin
            reg_enable <= enable_nxt;
        end
    end

    // ------------------------------------------------------------
    // all power good
    // ------------------------------------------------------------
    // judged on the enables about to be applied, so a newly enabled regulator holds it low
    logic pg_nxt;
    assign pg_nxt = ((enable_nxt & ~settled_s) == 3'b000);
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            all_power_good_oe <= 1'b1;
        end else begin
            all_power_good_oe <= !pg_nxt;
        end
    end

    // ------------------------------------------------------------
    // set-points
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            buck1_feedback <= `RSS_SETPOINT_RST;
            buckboost_feedback <= `RSS_SETPOINT_RST;
        end else if (host_setpoint_load) begin
            buck1_feedback <= host_setpoint1;
            buckboost_feedback <= host_setpoint3;
        end
    end

    // ------------------------------------------------------------
    // charger status and thermal pause
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            charge_pause <= 1'b0;
        end else begin
            charge_pause <= !temp_ok_s;
        end
    end

    rss_chg_t chg_state;
    assign chg_state = charge_pause ? RSS_CHG_TEMP :
                       bat_bad_s ? RSS_CHG_BADBAT :
                       charger_active ? RSS_CHG_ON : RSS_CHG_OFF;

    localparam logic [11:0] PERIOD = 12'(`RSS_CHG_PERIOD_CYC);
    localparam logic [11:0] DUTY_LO = 12'(`RSS_DUTY_LOW_CYC);
    localparam logic [11:0] DUTY_HI = 12'(`RSS_DUTY_HIGH_CYC);
    // slow alternation between duty levels so the bad-state codes are visible
    localparam logic [23:0] SLOW = 24'(`RSS_SLOW_DEFAULT);
    logic [11:0] mod_cnt_r;
    logic [23:0] slow_cnt_r;
    logic slow_ph_r;
    logic mod_wrap;
    assign mod_wrap = (mod_cnt_r == PERIOD - 12'd1);
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mod_cnt_r <= 12'd0;
            slow_cnt_r <= 24'd0;
            slow_ph_r <= 1'b0;
        end else begin
            mod_cnt_r <= mod_wrap ? 12'd0 : mod_cnt_r + 12'd1;
            if (mod_wrap) begin
                slow_cnt_r <= (slow_cnt_r == SLOW - 24'd1) ? 24'd0 : slow_cnt_r + 24'd1;
                if (slow_cnt_r == SLOW - 24'd1) begin
                    slow_ph_r <= !slow_ph_r;
                end
            end
        end
    end

    logic [11:0] duty;
    logic chg_low;
    always_comb begin
        duty = DUTY_LO;
        chg_low = 1'b0;
        unique case (chg_state)
            RSS_CHG_ON: chg_low = 1'b1;
            RSS_CHG_OFF: chg_low = 1'b0;
            RSS_CHG_BADBAT: begin
                duty = slow_ph_r ? DUTY_HI : DUTY_LO;
                chg_low = (mod_cnt_r < duty);
            end
            RSS_CHG_TEMP: begin
                duty = slow_ph_r ? DUTY_LO : DUTY_HI;
                chg_low = (mod_cnt_r < duty);
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            charge_status_out_oe <= 1'b0;
        end else begin
            charge_status_out_oe <= chg_low;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_pg_release: assert property (@(posedge clk) disable iff (!reset_n)
        !all_power_good_oe |-> ((reg_enable & ~$past(settled_s)) == 3'b000))
        else $error("power good released with an unsettled regulator");
    a_seq_wait: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == RSS_RAMP && en_all_s && !cur_settled) |=> seq_en_r == $past(seq_en_r))
        else $error("next regulator enabled before previous settled");
    a_seq_first: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == RSS_IDLE && en_all_s && seqsel == RSS_SEQ_FLOAT) |=> seq_en_r == 3'b001)
        else $error("floating select did not start with buck-boost");
    a_seq_all: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == RSS_DONE) |-> seq_en_r == 3'b111)
        else $error("sequence done without all regulators on");
    a_host_on: assert property (@(posedge clk) disable iff (!reset_n)
        host_enable.buck2 |=> reg_enable.buck2)
        else $error("host enable not applied");
    a_setpt_load: assert property (@(posedge clk) disable iff (!reset_n)
        host_setpoint_load |=> buck1_feedback == $past(host_setpoint1))
        else $error("set-point code not taken");
    a_temp_pause: assert property (@(posedge clk) disable iff (!reset_n)
        !temp_ok_s [*2] |-> charge_pause)
        else $error("charging not paused out of window");
    a_mod_period: assert property (@(posedge clk) disable iff (!reset_n)
        mod_wrap |=> mod_cnt_r == 12'd0 ##1 mod_cnt_r == 12'd1)
        else $error("modulation counter wrap wrong");
endmodule : rss_sequencer

// *** sim/rss_reg_model.sv ***
/*
 regulator model: settled follows enable after a soft-start delay.
 assumes enables come registered from the sequencer clock domain.
*/
`timescale 1ns/1ps
module rss_reg_model
    import rss_pkg::*;
#(
    parameter int SETTLE_CYC = 20
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // from the sequencer and bench
    input wire rss_regs_t reg_enable,
    input wire logic slow,
    // to the sequencer
    output rss_regs_t settled
);
    logic [2:0][7:0] cnt_r;
    always_ff @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (!reset_n || !reg_enable[i]) begin
                cnt_r[i] <= 8'h00;
            end else if (cnt_r[i] != 8'hFF) begin
                cnt_r[i] <= cnt_r[i] + 8'h01;
            end
        end
    end
    // slow mode stretches soft-start fourfold, to prove the ramp waits
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            settled[i] = cnt_r[i] >= (slow ? 8'(4 * SETTLE_CYC) : 8'(SETTLE_CYC));
        end
    end
endmodule : rss_reg_model

// *** sim/tb.sv ***
/*
 self-checking bench for the start-up sequencer.
 assumes the regulator model on the settled inputs and a 100 MHz clock.
*/
`timescale 1ns/1ps
`include "rss_params.svh"
module tb
    import rss_pkg::*;
;
    localparam int P = `RSS_CHG_PERIOD_CYC;
    localparam int L = `RSS_DUTY_LOW_CYC;
    localparam int H = `RSS_DUTY_HIGH_CYC;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic enable_all_input = 1'b0;
    logic seq_tied_high = 1'b0;
    logic seq_floating = 1'b0;
    logic slow = 1'b0;
    rss_regs_t host_enable = 3'h0;
    logic [3:0] host_setpoint1 = 4'h0;
    logic [3:0] host_setpoint3 = 4'h0;
    logic host_setpoint_load = 1'b0;
    rss_regs_t settled_in;
    logic thermistor_input = 1'b1;
    logic charger_active = 1'b0;
    logic battery_bad = 1'b0;
    rss_regs_t reg_enable;
    logic [3:0] buck1_feedback;
    logic [3:0] buckboost_feedback;
    logic charge_pause;
    logic all_power_good_oe;
    logic charge_status_out_oe;
    int errors = 0;
    int tests_run = 0;

    rss_sequencer dut (.clk, .reset_n, .enable_all_input, .seq_tied_high, .seq_floating,
        .host_enable, .host_setpoint1, .host_setpoint3, .host_setpoint_load, .settled_in,
        .thermistor_input, .charger_active, .battery_bad, .reg_enable, .buck1_feedback,
        .buckboost_feedback, .charge_pause, .all_power_good_oe, .charge_status_out_oe);
    rss_reg_model #(.SETTLE_CYC(20)) model (.clk, .reset_n, .reg_enable, .slow,
        .settled(settled_in));

    initial forever #5 clk = ~clk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic setpoint_case(input logic [3:0] a, input logic [3:0] b);
        @(posedge clk) begin
            host_setpoint1 <= a;
            host_setpoint3 <= b;
            host_setpoint_load <= 1'b1;
        end
        // codes move on the same edge the strobe drops; outputs must hold the loaded pair
        @(posedge clk) begin
            host_setpoint_load <= 1'b0;
            host_setpoint1 <= ~a;
            host_setpoint3 <= ~b;
        end
        tick(2);
        chk({buck1_feedback, buckboost_feedback}, {a, b});
    endtask : setpoint_case

    task automatic seq_case(input logic hi, input logic fl, input rss_regs_t s1, s2, s3);
        rss_regs_t exp [3];
        rss_regs_t prev;
        int step;
        int gap;
        exp = '{s1, s2, s3};
        prev = 3'h0;
        step = 0;
        gap = 0;
        @(posedge clk) begin
            seq_tied_high <= hi;
            seq_floating <= fl;
        end
        @(posedge clk) enable_all_input <= 1'b1;
        for (int c = 0; c < 2000 && step < 3; c++) begin
            tick(1);
            gap++;
            if (step == 1) seq_tied_high <= ~hi;
            if (reg_enable !== prev) begin
                chk(reg_enable, exp[step]);
                if (step > 0) chk(gap >= 20, 1'b1);
                if (step == 2) chk(all_power_good_oe, 1'b1);
                prev = reg_enable;
                step++;
                gap = 0;
            end
        end
        chk(step, 3);
        for (int c = 0; c < 200 && all_power_good_oe !== 1'b0; c++) tick(1);
        chk(all_power_good_oe, 1'b0);
        @(posedge clk) enable_all_input <= 1'b0;
        tick(6);
        chk(reg_enable, 3'h0);
    endtask : seq_case

    task automatic host_case();
        @(posedge clk) host_enable <= 3'b010;
        tick(3);
        chk(reg_enable, 3'b010);
        chk(all_power_good_oe, 1'b1);
        tick(40);
        chk(all_power_good_oe, 1'b0);
        @(posedge clk) host_enable <= 3'b000;
        tick(2);
        chk(reg_enable, 3'h0);
    endtask : host_case

    task automatic status_case(input logic act, bad, therm, tog);
        logic prev;
        int hi;
        @(posedge clk) begin
            charger_active <= act;
            battery_bad <= bad;
            thermistor_input <= therm;
        end
        tick(P);
        chk(charge_pause, !therm);
        prev = 1'b1;
        for (int c = 0; c < 2 * P && tog && !(!prev && charge_status_out_oe); c++) begin
            prev = charge_status_out_oe;
            tick(1);
        end
        hi = 0;
        for (int c = 0; c < P; c++) begin
            hi += (charge_status_out_oe === 1'b1);
            prev = charge_status_out_oe;
            tick(1);
        end
        if (tog) begin
            chk(hi, therm ? L : H);
            chk({prev, charge_status_out_oe}, 2'b01);
        end else begin
            chk(hi, act ? P : 0);
            chk(charge_status_out_oe, act);
        end
    endtask : status_case

    initial begin
        #800_000;
        errors++;
        conclude();
    end

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        tick(4);
        chk({buck1_feedback, buckboost_feedback}, 8'h00);
        setpoint_case(4'hA, 4'h5);
        setpoint_case(4'hF, 4'h0);
        seq_case(1'b0, 1'b0, 3'b100, 3'b110, 3'b111);
        seq_case(1'b1, 1'b0, 3'b100, 3'b101, 3'b111);
        seq_case(1'b0, 1'b1, 3'b001, 3'b101, 3'b111);
        @(posedge clk) slow <= 1'b1;
        seq_case(1'b1, 1'b1, 3'b001, 3'b101, 3'b111);
        @(posedge clk) slow <= 1'b0;
        host_case();
        status_case(1'b1, 1'b0, 1'b1, 1'b0);
        status_case(1'b0, 1'b0, 1'b1, 1'b0);
        status_case(1'b1, 1'b1, 1'b1, 1'b1);
        status_case(1'b1, 1'b1, 1'b0, 1'b1);
        status_case(1'b1, 1'b0, 1'b1, 1'b0);
        conclude();
    end
endmodule : tb
